// ### pitim_top.sv
`timescale 1ns/10ps
module pitim_top (
   // apb clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [pitim_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // timer reference pin
   input  wire logic                         timer_in,
   // timer output, active low
   output logic                              timer_out_n,
   // interrupt, active high level
   output logic                              irq
);

   // ==========================================================
   // reference clock edge
   logic tick;

   pitim_sync_edge u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (timer_in),
      .rise     (tick)
   );

   // ==========================================================
   // apb decode
   logic                         setup_w;
   logic                         wr_w;
   logic                         pready_r;
   logic                         pslverr_r;
   logic [31:0]                  prdata_r;
   logic [31:0]                  rdata_w;
   logic                         mapped_w;

   assign setup_w = psel && !penable;
   assign wr_w    = psel && penable && pready_r && pwrite;

   logic ctrl_wr;
   logic len_wr;
   logic start_w;
   logic stop_w;

   assign ctrl_wr = wr_w && pitim_pkg::pitim_hit(paddr, pitim_pkg::OFF_CTRL);
   assign len_wr  = wr_w && pitim_pkg::pitim_hit(paddr, pitim_pkg::OFF_LEN);
   // stop beats start when both are written together
   assign stop_w  = ctrl_wr && pwdata[pitim_pkg::CTRL_STOP];
   assign start_w = ctrl_wr && pwdata[pitim_pkg::CTRL_START] && !stop_w;

   // ==========================================================
   // configuration
   pitim_pkg::pitim_mode_e       mode_r;
   logic [pitim_pkg::CNT_W-1:0]  len_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= pitim_pkg::MODE_PULSE;
      end else if (ctrl_wr) begin
         mode_r <= pitim_pkg::pitim_mode_e'(pwdata[pitim_pkg::CTRL_MODE_LSB +: 2]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_r <= pitim_pkg::LEN_RST;
      end else if (len_wr) begin
         len_r <= pwdata[pitim_pkg::CNT_W-1:0];
      end
   end

   // ==========================================================
   // run state
   pitim_pkg::pitim_state_e      state_r;
   logic [pitim_pkg::CNT_W-1:0]  count_r;
   logic                         run_w;
   logic                         one_shot_w;
   logic                         tc_w;
   logic [pitim_pkg::CNT_W-1:0]  half_w;

   assign run_w      = (state_r == pitim_pkg::ST_RUN);
   assign one_shot_w = (mode_r == pitim_pkg::MODE_PULSE) ||
                       (mode_r == pitim_pkg::MODE_STROBE);
   // counts of 0 or 1 both end the period, so a zero length cannot wrap
   assign tc_w       = run_w && tick && (count_r <= pitim_pkg::CNT_ONE);
   assign half_w     = len_r >> 1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= pitim_pkg::ST_IDLE;
      end else begin
         case (state_r)
            pitim_pkg::ST_IDLE: begin
               if (start_w) begin
                  state_r <= pitim_pkg::ST_RUN;
               end
            end
            pitim_pkg::ST_RUN: begin
               if (stop_w) begin
                  state_r <= pitim_pkg::ST_IDLE;
               end else if (start_w) begin
                  state_r <= pitim_pkg::ST_RUN;
               end else if (tc_w && one_shot_w) begin
                  state_r <= pitim_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= pitim_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // reads of any register never reach this process
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= pitim_pkg::COUNT_RST;
      end else if (start_w) begin
         count_r <= len_r;
      end else if (tc_w) begin
         if (one_shot_w) begin
            count_r <= pitim_pkg::COUNT_RST;
         end else begin
            count_r <= len_r;
         end
      end else if (run_w && tick) begin
         count_r <= count_r - pitim_pkg::CNT_ONE;
      end
   end

   // ==========================================================
   // output level from registered state only
   logic low_w;

   always_comb begin
      low_w = 1'b0;
      if (run_w) begin
         case (mode_r)
            pitim_pkg::MODE_PULSE:  low_w = (count_r <= half_w);
            pitim_pkg::MODE_SQUARE: low_w = (count_r <= half_w);
            pitim_pkg::MODE_RATE:   low_w = (count_r <= pitim_pkg::CNT_ONE);
            pitim_pkg::MODE_STROBE: low_w = (count_r <= pitim_pkg::CNT_ONE);
            default:                low_w = 1'b0;
         endcase
      end
   end

   logic out_n_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_n_r <= 1'b1;
      end else begin
         out_n_r <= !low_w;
      end
   end

   // ==========================================================
   // interrupts
   logic [pitim_pkg::IRQ_W-1:0] ev_w;
   logic [pitim_pkg::IRQ_W-1:0] istat_w;
   logic [pitim_pkg::IRQ_W-1:0] imask_w;
   logic                        irq_w;

   assign ev_w[pitim_pkg::IRQ_TC]   = tc_w;
   assign ev_w[pitim_pkg::IRQ_DONE] = tc_w && one_shot_w;

   pitim_irq u_irq (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (ev_w),
      .clr_wr  (wr_w && pitim_pkg::pitim_hit(paddr, pitim_pkg::OFF_IRQ_STAT)),
      .mask_wr (wr_w && pitim_pkg::pitim_hit(paddr, pitim_pkg::OFF_IRQ_MASK)),
      .wdata   (pwdata[pitim_pkg::IRQ_W-1:0]),
      .stat_r  (istat_w),
      .mask_r  (imask_w),
      .irq_r   (irq_w)
   );

   // ==========================================================
   // read mux, sampled in the setup cycle
   always_comb begin
      rdata_w  = 32'h0000_0000;
      mapped_w = 1'b1;
      case (paddr)
         pitim_pkg::OFF_CTRL: begin
            rdata_w[pitim_pkg::CTRL_MODE_LSB +: 2] = mode_r;
         end
         pitim_pkg::OFF_LEN: begin
            rdata_w[pitim_pkg::CNT_W-1:0] = len_r;
         end
         pitim_pkg::OFF_COUNT: begin
            rdata_w[pitim_pkg::CNT_W-1:0] = count_r;
         end
         pitim_pkg::OFF_STAT: begin
            rdata_w[pitim_pkg::STAT_RUN] = run_w;
            rdata_w[pitim_pkg::STAT_OUT] = out_n_r;
         end
         pitim_pkg::OFF_IRQ_STAT: begin
            rdata_w[pitim_pkg::IRQ_W-1:0] = istat_w;
         end
         pitim_pkg::OFF_IRQ_MASK: begin
            rdata_w[pitim_pkg::IRQ_W-1:0] = imask_w;
         end
         default: begin
            mapped_w = 1'b0;
         end
      endcase
   end

   // one fixed wait-free answer: pready rises in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= setup_w;
         pslverr_r <= setup_w && !mapped_w;
         if (setup_w && !pwrite) begin
            prdata_r <= rdata_w;
         end
      end
   end

   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;
   assign timer_out_n = out_n_r;
   assign irq         = irq_w;

   // ==========================================================
   // assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // a length write in the terminal cycle would move the reload target
   sequence s_tc;
      tc_w && !ctrl_wr && !len_wr;
   endsequence

   sequence s_step;
      run_w && tick && (count_r > pitim_pkg::CNT_ONE) && !ctrl_wr;
   endsequence

   property p_count_step;
      s_step |=> (count_r == $past(count_r) - pitim_pkg::CNT_ONE);
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("count did not step down by one");

   property p_start_mode;
      start_w |=> run_w && (mode_r == $past(pwdata[1:0])) && (count_r == $past(len_r));
   endproperty
   a_start_mode: assert property (p_start_mode)
      else $error("start did not load mode and length");

   property p_pulse_low;
      run_w && (mode_r == pitim_pkg::MODE_PULSE) && (count_r <= half_w)
         |=> !timer_out_n;
   endproperty
   a_pulse_low: assert property (p_pulse_low)
      else $error("pulse output not low in second half");

   property p_square_high;
      run_w && (mode_r == pitim_pkg::MODE_SQUARE) && (count_r > half_w)
         |=> timer_out_n;
   endproperty
   a_square_high: assert property (p_square_high)
      else $error("square output not high in first half");

   property p_square_reload;
      s_tc ##0 (mode_r == pitim_pkg::MODE_SQUARE)
         |=> run_w && (count_r == len_r);
   endproperty
   a_square_reload: assert property (p_square_reload)
      else $error("square wave did not reload");

   property p_rate_pulse;
      s_tc ##0 (mode_r == pitim_pkg::MODE_RATE)
         |-> !timer_out_n ##1 (run_w && (count_r == len_r));
   endproperty
   a_rate_pulse: assert property (p_rate_pulse)
      else $error("rate generator missed pulse or restart");

   property p_strobe_once;
      s_tc ##0 (mode_r == pitim_pkg::MODE_STROBE)
         |-> !timer_out_n ##1 !run_w ##1 timer_out_n;
   endproperty
   a_strobe_once: assert property (p_strobe_once)
      else $error("strobe did not stop after one pulse");

   property p_read_count;
      setup_w && !pwrite && pitim_pkg::pitim_hit(paddr, pitim_pkg::OFF_COUNT)
         |=> (prdata[pitim_pkg::CNT_W-1:0] == $past(count_r));
   endproperty
   a_read_count: assert property (p_read_count)
      else $error("count read back wrong");

   property p_tc_irq;
      tc_w |=> istat_w[pitim_pkg::IRQ_TC] ##1 (irq == imask_w[pitim_pkg::IRQ_TC] ||
                                               irq);
   endproperty
   a_tc_irq: assert property (p_tc_irq)
      else $error("terminal count did not flag interrupt");

   property p_read_quiet;
      psel && !pwrite && !tick && !ctrl_wr |=> $stable(count_r) && $stable(state_r);
   endproperty
   a_read_quiet: assert property (p_read_quiet)
      else $error("read disturbed the counter");

   property p_done_flag;
      s_tc ##0 one_shot_w |=> istat_w[pitim_pkg::IRQ_DONE] && !run_w;
   endproperty
   a_done_flag: assert property (p_done_flag)
      else $error("one-shot end did not flag done");

   property p_idle_hold;
      !run_w && !ctrl_wr |=> $stable(count_r) && !run_w;
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("idle timer counted or restarted by itself");

   property p_ready_next;
      setup_w |=> pready && (pslverr == !$past(mapped_w));
   endproperty
   a_ready_next: assert property (p_ready_next)
      else $error("bus answer not in the access cycle");

endmodule

// ### pitim_pkg.sv
package pitim_pkg;

   // ==========================================================
   // widths
   localparam int CNT_W  = 14;
   localparam int ADDR_W = 8;
   localparam int IRQ_W  = 2;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_LEN      = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_COUNT    = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STAT     = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;

   // ==========================================================
   // field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_START    = 2;
   localparam int CTRL_STOP     = 3;
   localparam int STAT_RUN      = 0;
   localparam int STAT_OUT      = 1;
   localparam int IRQ_TC        = 0;
   localparam int IRQ_DONE      = 1;

   // ==========================================================
   // reset values and the count step
   localparam logic [CNT_W-1:0] LEN_RST   = 14'h0000;
   localparam logic [CNT_W-1:0] COUNT_RST = 14'h0000;
   localparam logic [IRQ_W-1:0] MASK_RST  = 2'h0;
   localparam logic [CNT_W-1:0] CNT_ONE   = 14'h0001;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      MODE_PULSE  = 2'h0,
      MODE_SQUARE = 2'h1,
      MODE_RATE   = 2'h2,
      MODE_STROBE = 2'h3
   } pitim_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } pitim_state_e;

   // address match, used by every register write decode; the read mux uses a case on paddr
   function automatic logic pitim_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] off);
      pitim_hit = (a == off);
   endfunction

endpackage

// ### pitim_sync_edge.sv
`timescale 1ns/10ps
module pitim_sync_edge (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // pin side
   input  wire logic async_in,
   // rising edge seen, one cycle
   output wire logic rise
);

   // ==========================================================
   // two-flop synchroniser, then edge detect on the second flop
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign rise = s2_r && !s3_r;

endmodule

// ### pitim_irq.sv
`timescale 1ns/10ps
module pitim_irq (
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // events, one cycle each
   input  wire logic [pitim_pkg::IRQ_W-1:0] ev,
   // software access
   input  wire logic                        clr_wr,
   input  wire logic                        mask_wr,
   input  wire logic [pitim_pkg::IRQ_W-1:0] wdata,
   // state
   output logic      [pitim_pkg::IRQ_W-1:0] stat_r,
   output logic      [pitim_pkg::IRQ_W-1:0] mask_r,
   output logic                             irq_r
);

   // ==========================================================
   // sticky bits: a set in the clear cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < pitim_pkg::IRQ_W; gi++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stat_r[gi] <= 1'b0;
            end else if (ev[gi]) begin
               stat_r[gi] <= 1'b1;
            end else if (clr_wr && wdata[gi]) begin
               stat_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= pitim_pkg::MASK_RST;
      end else if (mask_wr) begin
         mask_r <= wdata;
      end
   end

   // one cycle behind the status bit, keeps the output a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_r & mask_r);
      end
   end

endmodule

// ### pitim_ref_src.sv
`timescale 1ns/10ps
module pitim_ref_src (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // request from bench
   input  wire logic       fire,
   input  wire logic [2:0] hi_cyc,
   // reference pin
   output logic            timer_in
);
   logic [2:0] left_r;
   // ==========================================================
   // reference edges
   // pin falls low again between requests, so every edge is a fresh tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_r   <= 3'h0;
         timer_in <= 1'b0;
      end else if (fire) begin
         left_r   <= hi_cyc;
         timer_in <= 1'b1;
      end else if (left_r != 3'h0) begin
         left_r <= left_r - 3'h1;
      end else begin
         timer_in <= 1'b0;
      end
   end
endmodule

// ### programmable_interval_timer_14bit_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module programmable_interval_timer_14bit_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        timer_in, timer_out_n, irq, fire, err;
   logic [7:0]  paddr;
   logic [2:0]  hi_cyc;
   logic [31:0] pwdata, prdata, rd;
   int          miscompares, n_tests, seed, mcnt, mlen, mrun, mstat, mmask, m, i;

   // ==========================================================
   // design and reference source
   pitim_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_in(timer_in), .timer_out_n(timer_out_n), .irq(irq));
   pitim_ref_src u_ref (.pclk(pclk), .presetn(presetn), .fire(fire), .hi_cyc(hi_cyc),
      .timer_in(timer_in));

   always #2.5 pclk = ~pclk;

   // ==========================================================
   // bus and model tasks
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) miscompares++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      `CHK(nm, e, rd)
      `CHK("read err", 1'b0, err)
   endtask

   function automatic int exp_out();
      if (mrun == 0) return 1;
      if (m < 2) return (mcnt <= (mlen >> 1)) ? 0 : 1;
      return (mcnt == 1) ? 0 : 1;
   endfunction

   // synchroniser delay hidden by the fixed settle time
   task tick();
      fire   <= 1'b1;
      hi_cyc <= 3'h1 + 3'($unsigned($random(seed)) % 4);
      @(posedge pclk);
      fire <= 1'b0;
      repeat (12) @(posedge pclk);
      if (mrun != 0) begin
         if (mcnt <= 1) begin
            mstat |= 1;
            if (m == 0 || m == 3) begin
               mrun = 0;
               mcnt = 0;
               mstat |= 2;
            end else mcnt = mlen;
         end else mcnt--;
      end
   endtask

   task check_state();
      `CHK("timer_out_n", exp_out(), timer_out_n)
      `CHK("irq", ((mstat & mmask) != 0), irq)
      if (mrun != 0 || m != 3) begin
         rchk("count", pitim_pkg::OFF_COUNT, mcnt);
         rchk("count again", pitim_pkg::OFF_COUNT, mcnt);
      end
      rchk("stat", pitim_pkg::OFF_STAT, exp_out() * 2 + mrun);
      rchk("irq stat", pitim_pkg::OFF_IRQ_STAT, mstat);
      `CHK("out after reads", exp_out(), timer_out_n)
   endtask

   task print_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ==========================================================
   // watchdog, well past the few thousand cycles the run needs
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      print_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
      pwdata = 32'h00000000; fire = 0; hi_cyc = 3'h1; seed = 39548;
      miscompares = 0; n_tests = 0; m = 0; mrun = 0; mcnt = 0; mlen = 0; mstat = 0; mmask = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rchk("ctrl rst", pitim_pkg::OFF_CTRL, 32'h00000000);
      rchk("len rst", pitim_pkg::OFF_LEN, 32'h00000000);
      rchk("count rst", pitim_pkg::OFF_COUNT, 32'h00000000);
      rchk("stat rst", pitim_pkg::OFF_STAT, 32'h00000002);
      rchk("irq stat rst", pitim_pkg::OFF_IRQ_STAT, 32'h00000000);
      rchk("mask rst", pitim_pkg::OFF_IRQ_MASK, 32'h00000000);
      $display("test reset values done");
      apb(1'b0, 8'h18, 32'h00000000);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h00000000, rd)
      apb(1'b1, 8'h18, 32'hFFFFFFFF);
      `CHK("unmapped wr err", 1'b1, err)
      apb(1'b1, pitim_pkg::OFF_COUNT, 32'h00001234);
      rchk("count ro", pitim_pkg::OFF_COUNT, 32'h00000000);
      $display("test refusals done");
      for (m = 0; m < 4; m++) begin
         mlen = 2 + $unsigned($random(seed)) % 8;
         if (m == 0) mlen = 2 * (1 + $unsigned($random(seed)) % 4);
         mmask = (m == 2) ? 0 : 3;
         apb(1'b1, pitim_pkg::OFF_IRQ_MASK, mmask);
         apb(1'b1, pitim_pkg::OFF_IRQ_STAT, 32'h00000003);
         mstat = 0;
         apb(1'b1, pitim_pkg::OFF_LEN, mlen);
         apb(1'b1, pitim_pkg::OFF_CTRL, 32'h00000004 | m);
         mcnt = mlen;
         mrun = 1;
         apb(1'b0, pitim_pkg::OFF_CTRL, 32'h00000000);
         `CHK("mode", m, rd[1:0])
         check_state();
         for (i = 0; i < 2 * mlen + 2; i++) begin
            tick();
            check_state();
            // restart in mid-count reloads the length
            if (i == 1) begin
               apb(1'b1, pitim_pkg::OFF_CTRL, 32'h00000004 | m);
               mcnt = mlen;
               mrun = 1;
               repeat (2) @(posedge pclk);
               check_state();
            end
         end
         if (mrun != 0) begin
            // start and stop together: stop must win
            apb(1'b1, pitim_pkg::OFF_CTRL, 32'h0000000C | m);
            mrun = 0;
            repeat (2) @(posedge pclk);
            check_state();
            tick();
            check_state();
         end
         $display("test mode %0d done", m);
      end
      mmask = 3;
      apb(1'b1, pitim_pkg::OFF_IRQ_MASK, mmask);
      repeat (2) @(posedge pclk);
      `CHK("irq unmasked", 1'b1, irq)
      apb(1'b1, pitim_pkg::OFF_IRQ_STAT, 32'h00000001);
      rchk("irq stat w1c", pitim_pkg::OFF_IRQ_STAT, 32'h00000002);
      apb(1'b1, pitim_pkg::OFF_IRQ_STAT, 32'h00000002);
      repeat (2) @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      $display("test irq clear done");
      print_verdict();
   end
endmodule
